/* hw/dcc_edge_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser plus edge detector for one raw comparator output
module dcc_edge_sync
    import dcc_pkg::*;
#(
    parameter int unsigned STAGES = SYNC_STAGES
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_raw,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic [STAGES-1:0] sync_ff;
    logic [STAGES-1:0] nxt_sync;
    logic              last_ff;
    logic              nxt_last;

    // a single stage would leave the first flop's metastability visible
    if (STAGES < 2) begin : g_bad_stages
        $error("dcc_edge_sync needs at least two stages");
    end

    always_comb begin
        nxt_sync = {sync_ff[STAGES-2:0], i_raw};
        nxt_last = sync_ff[STAGES-1];
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sync_ff <= '0;
            last_ff <= 1'b0;
        end else begin
            sync_ff <= nxt_sync;
            last_ff <= nxt_last;
        end
    end

    // only the last stage is looked at
    assign o_level = sync_ff[STAGES-1];
    assign o_rise  = sync_ff[STAGES-1] & ~last_ff;
    assign o_fall  = ~sync_ff[STAGES-1] & last_ff;
endmodule : dcc_edge_sync
`default_nettype wire

/* hw/dcc_regs.sv */
// Operation
// - control bit 7 enables comparator a
// - control bit 6 reads comparator a output, read-only
// - control bit 5 sets on rising edge, held until software writes 0
// - control bit 4 sets on falling edge, held until software writes 0
// - control bits 3-2 drive positive hysteresis code to analog core
// - control bits 1-0 drive negative hysteresis code to analog core
// - mux bits 5-4 select negative input pin of comparator a
// - mux bits 1-0 select positive input pin of comparator a
// - mux bits 7-6 and 3-2 read 11b, ignore writes; reset all ones
// - mode bits 7-6 and 3-2 read 00b and ignore writes
// - mode bit 5 enables rising-edge interrupt of comparator a
// - mode bit 4 enables falling-edge interrupt of comparator a
// - mode bits 1-0 drive response-time code to analog core
// - comparator b control register has same layout and enable
// - comparator b control bit 6 reads its output, read-only
// - comparator b edge flags set on edges, held until cleared
// - comparator b mux bits 5-4 select its negative input
// - comparator b mux bits 1-0 select its positive input
// - comparator b mode register at 0x9c matches comparator a's
// - disabled comparator output is held low toward the pin
`timescale 1ns/1ns
`default_nettype none
module dcc_regs
    import dcc_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire logic [DATA_W-1:0] i_wdata,
    output logic      [DATA_W-1:0] o_rdata,
    input  wire logic              i_cmp_a_raw,
    input  wire logic              i_cmp_b_raw,
    output logic                   o_cmp_a_enable,
    output logic                   o_cmp_b_enable,
    output logic      [1:0]        o_cmp_a_pos_hyst,
    output logic      [1:0]        o_cmp_a_neg_hyst,
    output logic      [1:0]        o_cmp_b_pos_hyst,
    output logic      [1:0]        o_cmp_b_neg_hyst,
    output logic      [1:0]        o_cmp_a_speed_mode,
    output logic      [1:0]        o_cmp_b_speed_mode,
    output logic      [1:0]        o_cmp_a_pos_input_sel,
    output logic      [1:0]        o_cmp_a_neg_input_sel,
    output logic      [1:0]        o_cmp_b_pos_input_sel,
    output logic      [1:0]        o_cmp_b_neg_input_sel,
    output logic                   o_cmp_a_sync_out,
    output logic                   o_cmp_b_sync_out,
    output logic                   o_cmp_a_irq,
    output logic                   o_cmp_b_irq
);
    // per comparator: index 0 is comparator a, 1 is comparator b
    logic [7:0] ctl_ff  [2];
    logic [7:0] mode_ff [2];
    logic [7:0] mux_ff  [2];
    logic [7:0] nxt_ctl [2];
    logic [7:0] nxt_mode[2];
    logic [7:0] nxt_mux [2];
    logic [1:0] irq_ff;
    logic [1:0] nxt_irq;
    logic [1:0] pin_ff;
    logic [1:0] nxt_pin;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [1:0] level;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] raw;
    logic [7:0] ctl_addr [2];
    logic [7:0] mode_addr[2];
    logic [7:0] mux_addr [2];

    assign raw       = {i_cmp_b_raw, i_cmp_a_raw};
    assign ctl_addr  = '{CMP_A_CONTROL_ADDR, CMP_B_CONTROL_ADDR};
    assign mode_addr = '{CMP_A_MODE_ADDR, CMP_B_MODE_ADDR};
    assign mux_addr  = '{CMP_A_INPUT_SELECT_ADDR, CMP_B_INPUT_SELECT_ADDR};

    for (genvar g = 0; g < 2; g++) begin : g_cmp
        // analog output crosses into the clock domain first
        dcc_edge_sync #(
            .STAGES (SYNC_STAGES)
        ) u_sync (
            .i_clk   (i_clk),
            .i_reset (i_reset),
            .i_raw   (raw[g]),
            .o_level (level[g]),
            .o_rise  (rise[g]),
            .o_fall  (fall[g])
        );

        always_comb begin
            nxt_ctl[g]  = ctl_ff[g];
            nxt_mode[g] = mode_ff[g];
            nxt_mux[g]  = mux_ff[g];
            if (i_wr && i_addr == ctl_addr[g]) begin
                nxt_ctl[g] = i_wdata;
            end
            // output bit is live state, never stored from a write
            nxt_ctl[g][CTL_OUTPUT_BIT] = level[g];
            // an edge wins over a clearing write in the same cycle
            if (rise[g]) begin
                nxt_ctl[g][CTL_RISE_BIT] = 1'b1;
            end
            if (fall[g]) begin
                nxt_ctl[g][CTL_FALL_BIT] = 1'b1;
            end
            if (i_wr && i_addr == mode_addr[g]) begin
                nxt_mode[g] = i_wdata & MODE_USED_MASK;
            end
            if (i_wr && i_addr == mux_addr[g]) begin
                nxt_mux[g] = i_wdata | MUX_UNUSED_MASK;
            end
            nxt_irq[g] = (nxt_ctl[g][CTL_RISE_BIT] & nxt_mode[g][MODE_RIE_BIT])
                       | (nxt_ctl[g][CTL_FALL_BIT] & nxt_mode[g][MODE_FIE_BIT]);
            // disabled comparator drives low toward the pin
            nxt_pin[g] = nxt_ctl[g][CTL_ENABLE_BIT] & level[g];
        end

        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
                ctl_ff[g]  <= CONTROL_RESET;
                mode_ff[g] <= MODE_RESET;
                mux_ff[g]  <= MUX_RESET;
                irq_ff[g]  <= 1'b0;
                pin_ff[g]  <= 1'b0;
            end else begin
                ctl_ff[g]  <= nxt_ctl[g];
                mode_ff[g] <= nxt_mode[g];
                mux_ff[g]  <= nxt_mux[g];
                irq_ff[g]  <= nxt_irq[g];
                pin_ff[g]  <= nxt_pin[g];
            end
        end
    end

    // read data registered; unmapped addresses read zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (i_rd) begin
            case (i_addr)
                CMP_B_CONTROL_ADDR:      nxt_rdata = ctl_ff[1];
                CMP_A_CONTROL_ADDR:      nxt_rdata = ctl_ff[0];
                CMP_B_MODE_ADDR:         nxt_rdata = mode_ff[1];
                CMP_A_MODE_ADDR:         nxt_rdata = mode_ff[0];
                CMP_B_INPUT_SELECT_ADDR: nxt_rdata = mux_ff[1];
                CMP_A_INPUT_SELECT_ADDR: nxt_rdata = mux_ff[0];
                default:                 nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata               = rdata_ff;
    assign o_cmp_a_enable        = ctl_ff[0][CTL_ENABLE_BIT];
    assign o_cmp_b_enable        = ctl_ff[1][CTL_ENABLE_BIT];
    assign o_cmp_a_pos_hyst      = ctl_ff[0][CTL_PHYST_LSB +: 2];
    assign o_cmp_a_neg_hyst      = ctl_ff[0][CTL_NHYST_LSB +: 2];
    assign o_cmp_b_pos_hyst      = ctl_ff[1][CTL_PHYST_LSB +: 2];
    assign o_cmp_b_neg_hyst      = ctl_ff[1][CTL_NHYST_LSB +: 2];
    assign o_cmp_a_speed_mode    = mode_ff[0][MODE_SPEED_LSB +: 2];
    assign o_cmp_b_speed_mode    = mode_ff[1][MODE_SPEED_LSB +: 2];
    assign o_cmp_a_pos_input_sel = mux_ff[0][MUX_POS_LSB +: 2];
    assign o_cmp_a_neg_input_sel = mux_ff[0][MUX_NEG_LSB +: 2];
    assign o_cmp_b_pos_input_sel = mux_ff[1][MUX_POS_LSB +: 2];
    assign o_cmp_b_neg_input_sel = mux_ff[1][MUX_NEG_LSB +: 2];
    assign o_cmp_a_sync_out      = pin_ff[0];
    assign o_cmp_b_sync_out      = pin_ff[1];
    assign o_cmp_a_irq           = irq_ff[0];
    assign o_cmp_b_irq           = irq_ff[1];
endmodule : dcc_regs
`default_nettype wire

/* shared/dcc_pkg.sv */
package dcc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [7:0] CMP_B_CONTROL_ADDR      = 8'h9a;
    localparam logic [7:0] CMP_A_CONTROL_ADDR      = 8'h9b;
    localparam logic [7:0] CMP_B_MODE_ADDR         = 8'h9c;
    localparam logic [7:0] CMP_A_MODE_ADDR         = 8'h9d;
    localparam logic [7:0] CMP_B_INPUT_SELECT_ADDR = 8'h9e;
    localparam logic [7:0] CMP_A_INPUT_SELECT_ADDR = 8'h9f;

    localparam int unsigned CTL_ENABLE_BIT = 7;
    localparam int unsigned CTL_OUTPUT_BIT = 6;
    localparam int unsigned CTL_RISE_BIT   = 5;
    localparam int unsigned CTL_FALL_BIT   = 4;
    localparam int unsigned CTL_PHYST_LSB  = 2;
    localparam int unsigned CTL_NHYST_LSB  = 0;
    localparam int unsigned MODE_RIE_BIT   = 5;
    localparam int unsigned MODE_FIE_BIT   = 4;
    localparam int unsigned MODE_SPEED_LSB = 0;
    localparam int unsigned MUX_NEG_LSB    = 4;
    localparam int unsigned MUX_POS_LSB    = 0;

    localparam logic [7:0] CONTROL_RESET   = 8'h00;
    localparam logic [7:0] MODE_RESET      = 8'h02;
    localparam logic [7:0] MUX_RESET       = 8'hff;
    localparam logic [7:0] MUX_UNUSED_MASK = 8'hcc;
    localparam logic [7:0] MODE_USED_MASK  = 8'h33;

    localparam int unsigned SYNC_STAGES = 2;
endpackage : dcc_pkg

/* sim/dcc_analog_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dcc_analog_model (
    input  wire logic [1:0] i_speed,
    input  wire logic       i_above,
    output logic            o_raw
);
    int t_ns;
    always @* t_ns = i_speed[1] ? (i_speed[0] ? 1050 : 320) : (i_speed[0] ? 175 : 100);
    initial o_raw = 1'b0;
    // transport delay plus skew: the slowest mode would land on a rising edge
    always @(i_above) o_raw <= #(t_ns + 10) i_above;
endmodule : dcc_analog_model
`default_nettype wire

/* sim/dcc_regs_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module dcc_regs_monitor (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic [7:0] i_addr,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic       i_cmp_a_raw,
    input wire logic       o_cmp_a_enable,
    input wire logic [1:0] o_cmp_a_pos_hyst,
    input wire logic [1:0] o_cmp_a_neg_hyst,
    input wire logic [1:0] o_cmp_a_speed_mode,
    input wire logic       o_cmp_a_sync_out,
    input wire logic       o_cmp_a_irq
);
    logic [7:0] wd_ff;
    always_ff @(posedge i_clk) wd_ff <= i_wdata;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    property p_en; i_wr && i_addr == 8'h9b |=> o_cmp_a_enable == wd_ff[7]; endproperty
    a_en: assert property (p_en) else $error("enable");
    property p_hys; i_wr && i_addr == 8'h9b |=> {o_cmp_a_pos_hyst, o_cmp_a_neg_hyst} ==
        wd_ff[3:0]; endproperty
    a_hys: assert property (p_hys) else $error("hyst");
    property p_spd; i_wr && i_addr == 8'h9d |=> o_cmp_a_speed_mode == wd_ff[1:0]; endproperty
    a_spd: assert property (p_spd) else $error("speed");
    property p_mux; i_rd && i_addr[7:1] == 7'h4f |=> (o_rdata & 8'hcc) == 8'hcc; endproperty
    a_mux: assert property (p_mux) else $error("mux pad");
    property p_md; i_rd && i_addr[7:1] == 7'h4e |=> (o_rdata & 8'hcc) == 8'h00; endproperty
    a_md: assert property (p_md) else $error("mode pad");
    property p_off; !o_cmp_a_enable |-> !o_cmp_a_sync_out; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_syn; o_cmp_a_enable && $rose(i_cmp_a_raw) ##1 (o_cmp_a_enable && i_cmp_a_raw)[*4]
        |-> o_cmp_a_sync_out; endproperty
    a_syn: assert property (p_syn) else $error("sync");
    property p_irq; o_cmp_a_irq && !i_wr |=> o_cmp_a_irq; endproperty
    a_irq: assert property (p_irq) else $error("irq");
    c_irq: cover property ($rose(o_cmp_a_irq));
    c_syn: cover property ($rose(o_cmp_a_sync_out));
    c_md: cover property (i_rd && i_addr == 8'h9d);
endmodule : dcc_regs_monitor
bind dcc_regs dcc_regs_monitor u_mon (.*);
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
    logic       i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0, rd_q = 0;
    logic [7:0] i_addr = 0, i_wdata = 0, w, got, exp_q[$];
    logic [1:0] above = 0;
    wire logic [1:0] raw, sync, irq, spd_a, spd_b, en;
    wire logic [3:0] hys_a, hys_b, sel_a, sel_b;
    wire logic [7:0] o_rdata;
    int         fails = 0, num_checks = 0, seed = 58487, n;
    logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'hff, 8'hff, 8'h00};
    logic [7:0] am[7] = '{8'hbf, 8'hbf, 8'h33, 8'h33, 8'hff, 8'hff, 8'h00};
    dcc_regs u_dut (.i_clk, .i_reset, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata,
        .i_cmp_a_raw(raw[0]), .i_cmp_b_raw(raw[1]), .o_cmp_a_enable(en[0]),
        .o_cmp_b_enable(en[1]), .o_cmp_a_pos_hyst(hys_a[3:2]), .o_cmp_a_neg_hyst(hys_a[1:0]),
        .o_cmp_b_pos_hyst(hys_b[3:2]), .o_cmp_b_neg_hyst(hys_b[1:0]),
        .o_cmp_a_speed_mode(spd_a), .o_cmp_b_speed_mode(spd_b),
        .o_cmp_a_pos_input_sel(sel_a[1:0]), .o_cmp_a_neg_input_sel(sel_a[3:2]),
        .o_cmp_b_pos_input_sel(sel_b[1:0]), .o_cmp_b_neg_input_sel(sel_b[3:2]),
        .o_cmp_a_sync_out(sync[0]), .o_cmp_b_sync_out(sync[1]), .o_cmp_a_irq(irq[0]),
        .o_cmp_b_irq(irq[1]));
    dcc_analog_model u_core_a (.i_speed(spd_a), .i_above(above[0]), .o_raw(raw[0]));
    dcc_analog_model u_core_b (.i_speed(spd_b), .i_above(above[1]), .o_raw(raw[1]));
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) rd_q <= i_rd;
    always @(negedge i_clk) if (rd_q) begin
        got = exp_q.pop_front();
        `CHK(o_rdata, got)
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk) {i_addr, i_wdata, i_wr} = {a, d, 1'b1};
        @(negedge i_clk) i_wr = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk) {i_addr, i_rd} = {a, 1'b1};
        exp_q.push_back(e);
        @(negedge i_clk) i_rd = 0;
    endtask : rd
    task automatic end_sim();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        repeat (8) @(negedge i_clk);
        i_reset = 0;
        for (int r = 0; r < 7; r++) rd(8'h9a + 8'(r), rv[r]);
        // unmapped 0xa0 included: reads back zero
        for (int r = 0; r < 21; r++) begin
            w = 8'($random(seed));
            wr(8'h9a + 8'(r % 7), w);
            if (r % 7 == 4) `CHK(sel_b, ({w[5:4], w[1:0]}))
            if (r % 7 == 5) `CHK(sel_a, ({w[5:4], w[1:0]}))
            rd(8'h9a + 8'(r % 7), (w & am[r % 7]) | (rv[r % 7] & 8'hcc));
        end
        for (int c = 0; c < 2; c++) for (int k = 0; k < 4; k++) begin
            w = 8'h80 | 8'(k * 5);
            wr(8'h9b - 8'(c), w);
            wr(8'h9d - 8'(c), 8'h20 | 8'(k));
            `CHK(({en[c], c ? hys_b : hys_a}), ({1'b1, w[3:0]}))
            `CHK((c ? spd_b : spd_a), 2'(k))
            above[c] = 1;
            for (n = 0; n < 40 && sync[c] !== 1'b1; n++) @(negedge i_clk);
            `CHK(sync[c], 1'b1)
            `CHK(irq[c], 1'b1)
            rd(8'h9b - 8'(c), w | 8'h60);
            wr(8'h9d - 8'(c), 8'h10 | 8'(k));
            `CHK(irq[c], 1'b0)
            above[c] = 0;
            for (n = 0; n < 40 && sync[c] !== 1'b0; n++) @(negedge i_clk);
            `CHK(sync[c], 1'b0)
            `CHK(irq[c], 1'b1)
            rd(8'h9b - 8'(c), w | 8'h30);
            wr(8'h9d - 8'(c), 8'h00);
            `CHK(irq[c], 1'b0)
        end
        // disabled comparator still flags edges; clearing write meets a rising edge
        wr(8'h9b, 8'h00);
        above[0] = 1;
        repeat (2) @(negedge i_clk);
        wr(8'h9b, 8'h00);
        rd(8'h9b, 8'h60);
        `CHK(sync[0], 1'b0)
        wr(8'h9b, 8'h80);
        wr(8'h9b, 8'h80);
        rd(8'h9b, 8'hc0);
        `CHK(sync[0], 1'b1)
        end_sim();
    end
    initial begin
        #500_000 fails++;
        end_sim();
    end
endmodule : testbench
`default_nettype wire
